// ---- src/tpe_engine.sv ----
/*
  Table push/pop engine: a flip-flop word memory, a circular write of a
  source word into a table, and a pop from the table top with upward
  shift.  Popped words also leave through a small queue.
  Assumes the controller issues at most one request per scan, marks each
  scan end with a pulse, and drives all inputs from the same clock.
*/
`timescale 1ns/1ps
`include "tpe_map.svh"

module tpe_engine (
  input  wire logic                   clk_in,
  input  wire logic                   rstn_in,
  input  wire logic                   exec_in,
  input  wire logic                   op_sel_in,
  input  wire logic                   enable_in,
  input  wire logic                   scan_end_in,
  input  wire logic [`TPE_WORD_W-1:0] base_addr_in,
  input  wire logic [`TPE_LEN_W-1:0]  table_len_in,
  input  wire logic [`TPE_WORD_W-1:0] operand_addr_in,
  input  wire logic                   mem_wr_in,
  input  wire logic                   mem_rd_in,
  input  wire logic [`TPE_WORD_W-1:0] mem_addr_in,
  input  wire logic [`TPE_WORD_W-1:0] mem_wdata_in,
  output logic      [`TPE_WORD_W-1:0] mem_rdata_out,
  output logic                        mem_rvalid_out,
  output logic                        busy_out,
  output logic                        done_out,
  output logic                        table_status_flag_out,
  output logic                        pop_valid_out,
  output logic      [`TPE_WORD_W-1:0] pop_data_out,
  input  wire logic                   pop_ready_in
);

  localparam int unsigned DEPTH = `TPE_MEM_DEPTH;

  // ----------------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------------
  // Word addresses beyond the memory fold onto it by truncation
  function automatic logic [`TPE_IDX_W-1:0] idx_of(
    input logic [`TPE_WORD_W-1:0] base,
    input logic [`TPE_WORD_W-1:0] off
  );
    logic [`TPE_WORD_W-1:0] sum;
    sum = base + off;
    return sum[`TPE_IDX_W-1:0];
  endfunction : idx_of

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  tpe_pkg::tpe_state_t     state_reg;
  logic [`TPE_WORD_W-1:0]  mem_reg [0:DEPTH-1];
  logic [`TPE_WORD_W-1:0]  base_reg;
  logic [`TPE_LEN_W-1:0]   len_reg;
  logic [`TPE_WORD_W-1:0]  oper_reg;
  logic [`TPE_WORD_W-1:0]  cnt_reg;
  logic [`TPE_WORD_W-1:0]  idx_reg;
  logic                    ran_reg;
  logic                    flag_reg;
  logic                    done_reg;
  logic                    busy_reg;
  logic [`TPE_WORD_W-1:0]  rdata_reg;
  logic                    rvalid_reg;

  logic                    idle;
  logic                    take;
  logic                    wr_take;
  logic                    pop_take;
  logic                    pop_ok;
  logic                    pop_skip;
  logic                    pop_fire;
  logic                    shift_on;
  logic                    shift_last;
  logic                    host_we;
  logic [`TPE_WORD_W-1:0]  cur_base;
  logic [`TPE_LEN_W-1:0]   cur_len;
  logic [`TPE_WORD_W-1:0]  cur_oper;
  logic [`TPE_WORD_W-1:0]  head_word;
  logic [`TPE_WORD_W-1:0]  top_word;
  logic [`TPE_WORD_W-1:0]  len_word;

  logic [`TPE_WORD_W-1:0]  slot_off;
  logic [`TPE_WORD_W-1:0]  next_ptr;
  logic                    store_ok;
  logic                    at_end;

  logic                    we_a;
  logic [`TPE_IDX_W-1:0]   addr_a;
  logic [`TPE_WORD_W-1:0]  data_a;
  logic                    we_b;
  logic [`TPE_IDX_W-1:0]   addr_b;
  logic [`TPE_WORD_W-1:0]  data_b;

  logic                    q_ready;

  // ----------------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------------
  // A second request in the same scan is dropped, so a held enable
  // still yields one execution per scan
  assign idle     = (state_reg == tpe_pkg::tpe_st_idle);
  assign take     = idle && exec_in && enable_in && !ran_reg;
  assign wr_take  = take && (op_sel_in == `TPE_OP_WRITE);
  assign pop_take = take && (op_sel_in == `TPE_OP_POP);

  // Operands come straight from the ports while idle, else from latches
  assign cur_base = idle ? base_addr_in    : base_reg;
  assign cur_len  = idle ? table_len_in    : len_reg;
  assign cur_oper = idle ? operand_addr_in : oper_reg;
  assign len_word = {{(`TPE_WORD_W-`TPE_LEN_W){1'b0}}, cur_len};

  // The base word is pointer or counter, never table data
  assign head_word = mem_reg[idx_of(cur_base, `TPE_WORD_ZERO)];
  assign top_word  = mem_reg[idx_of(cur_base, `TPE_WORD_ONE)];

  // Pop validity: counter within one..length
  assign pop_ok   = (head_word != `TPE_WORD_ZERO) &&
                    (head_word <= len_word);
  assign pop_skip = pop_take && !pop_ok;

  // The pop starts only once the queue has room for the popped word
  assign pop_fire = ((pop_take && pop_ok) ||
                     (state_reg == tpe_pkg::tpe_st_qwait)) && q_ready;
  assign shift_on   = (state_reg == tpe_pkg::tpe_st_shift);
  assign shift_last = (idx_reg == cnt_reg);

  // Host writes lose to the engine; they are dropped while busy
  assign host_we = mem_wr_in && idle && !take;

  // ----------------------------------------------------------------------
  // Write pointer step
  // ----------------------------------------------------------------------
  tpe_stt_step u_step (
    .ptr_in       (head_word),
    .len_in       (cur_len),
    .slot_off_out (slot_off),
    .next_ptr_out (next_ptr),
    .store_ok_out (store_ok),
    .at_end_out   (at_end)
  );

  // ----------------------------------------------------------------------
  // Engine write ports
  // ----------------------------------------------------------------------
  // Port b carries pointer or counter and is applied after port a
  always_comb
  begin
    we_a   = 1'b0;
    addr_a = '0;
    data_a = `TPE_WORD_ZERO;
    we_b   = 1'b0;
    addr_b = '0;
    data_b = `TPE_WORD_ZERO;
    if (wr_take && store_ok)
    begin
      we_a   = 1'b1;
      addr_a = idx_of(cur_base, slot_off);
      data_a = mem_reg[idx_of(cur_oper, `TPE_WORD_ZERO)];
      we_b   = 1'b1;
      addr_b = idx_of(cur_base, `TPE_WORD_ZERO);
      data_b = next_ptr;
    end
    else if (pop_fire)
    begin
      we_a   = 1'b1;
      addr_a = idx_of(cur_oper, `TPE_WORD_ZERO);
      data_a = top_word;
    end
    else if (shift_on)
    begin
      // Slots past the counter stay as they are; the last one vacates
      we_a   = 1'b1;
      addr_a = idx_of(base_reg, idx_reg);
      data_a = shift_last ? `TPE_WORD_ZERO
               : mem_reg[idx_of(base_reg, idx_reg + `TPE_WORD_ONE)];
      if (shift_last)
      begin
        we_b   = 1'b1;
        addr_b = idx_of(base_reg, `TPE_WORD_ZERO);
        data_b = cnt_reg - `TPE_WORD_ONE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Word memory
  // ----------------------------------------------------------------------
  // Counter word is never seeded here; software must write it first
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= `TPE_WORD_ZERO;
    end
    else
    begin
      if (host_we)
        mem_reg[idx_of(mem_addr_in, `TPE_WORD_ZERO)] <= mem_wdata_in;
      if (we_a)
        mem_reg[addr_a] <= data_a;
      if (we_b)
        mem_reg[addr_b] <= data_b;
    end
  end

  // Registered host read, one cycle after the strobe
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_reg  <= `TPE_WORD_ZERO;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= mem_rd_in;
      if (mem_rd_in)
        rdata_reg <= mem_reg[idx_of(mem_addr_in, `TPE_WORD_ZERO)];
    end
  end

  // ----------------------------------------------------------------------
  // Pop sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= tpe_pkg::tpe_st_idle;
      busy_reg  <= 1'b0;
    end
    else
    begin
      case (state_reg)
        tpe_pkg::tpe_st_idle:
        begin
          if (pop_take && pop_ok)
          begin
            state_reg <= q_ready ? tpe_pkg::tpe_st_shift
                                 : tpe_pkg::tpe_st_qwait;
            busy_reg  <= 1'b1;
          end
        end
        tpe_pkg::tpe_st_qwait:
        begin
          if (q_ready)
            state_reg <= tpe_pkg::tpe_st_shift;
        end
        tpe_pkg::tpe_st_shift:
        begin
          if (shift_last)
          begin
            state_reg <= tpe_pkg::tpe_st_idle;
            busy_reg  <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= tpe_pkg::tpe_st_idle;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // Operand latches, captured when a request is taken
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      base_reg <= `TPE_WORD_ZERO;
      len_reg  <= '0;
      oper_reg <= `TPE_WORD_ZERO;
      cnt_reg  <= `TPE_WORD_ZERO;
    end
    else if (take)
    begin
      base_reg <= base_addr_in;
      len_reg  <= table_len_in;
      oper_reg <= operand_addr_in;
      cnt_reg  <= head_word;
    end
  end

  // Shift index walks slots one..counter from the table top
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      idx_reg <= `TPE_WORD_ZERO;
    else if (pop_fire)
      idx_reg <= `TPE_WORD_ONE;
    else if (shift_on && !shift_last)
      idx_reg <= idx_reg + `TPE_WORD_ONE;
  end

  // ----------------------------------------------------------------------
  // Scan bookkeeping and status
  // ----------------------------------------------------------------------
  // A take in the scan-end cycle counts for the new scan
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      ran_reg <= 1'b0;
    else if (take)
      ran_reg <= 1'b1;
    else if (scan_end_in)
      ran_reg <= 1'b0;
  end

  // Every flag-using op overwrites the flag; an update beats scan end
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      flag_reg <= `TPE_FLAG_RST;
    else if (wr_take)
      flag_reg <= at_end;
    else if (pop_skip)
      flag_reg <= 1'b1;
    else if (shift_on && shift_last)
      flag_reg <= (cnt_reg == `TPE_WORD_ONE);
    else if (scan_end_in)
      flag_reg <= 1'b0;
  end

  // Completion pulse for every finished or skipped operation
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      done_reg <= 1'b0;
    else
      done_reg <= wr_take || pop_skip || (shift_on && shift_last);
  end

  // ----------------------------------------------------------------------
  // Popped-word queue
  // ----------------------------------------------------------------------
  // A full queue holds the pop in wait, so the consumer throttles pops
  tpe_fifo #(
    .WIDTH (`TPE_WORD_W),
    .DEPTH (`TPE_FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (pop_fire),
    .in_data_in    (top_word),
    .in_ready_out  (q_ready),
    .out_valid_out (pop_valid_out),
    .out_data_out  (pop_data_out),
    .out_ready_in  (pop_ready_in)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign mem_rdata_out         = rdata_reg;
  assign mem_rvalid_out        = rvalid_reg;
  assign busy_out              = busy_reg;
  assign done_out              = done_reg;
  assign table_status_flag_out = flag_reg;

endmodule : tpe_engine

// ---- src/tpe_map.svh ----
/*
  Constants of the table push/pop engine: word and index widths, memory
  depth, operation codes, pointer values and queue depth.
  Assumes it is included by bare name wherever a constant is needed.
*/
//
// Contract
// - Write op copies source word to slot chosen by pointer, then pointer+1.
// - Write pointer at last slot wraps to one, never zero.
// - Write pointer lives in the word at table base address.
// - Each operation executes once per scan while its enable stays on; engine allows one execution per scan shared by write and pop.
// - Program loads base address; device uses that word as pointer, not data.
// - Write pointer out of range means nothing is stored.
// - Write op raises status flag when pointer equals table length.
// - Status flag holds only until scan end or next flag-using op.
// - Pointer zero and pointer equal to length both select first slot.
// - Pop moves top value to destination and shifts remaining values up.
// - Pop keeps a length counter in the base word, decremented each run.
// - Pop counter zero or above length: skip and raise status flag.
// - Pop raises status flag when length counter reaches zero.
// - Pop slots count from table top; counter N touches first N slots.
//
`ifndef TPE_MAP_SVH
`define TPE_MAP_SVH

// ----------------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------------
`define TPE_WORD_W      16
`define TPE_LEN_W       8
`define TPE_IDX_W       9
`define TPE_MEM_DEPTH   512
`define TPE_FIFO_DEPTH  4

// ----------------------------------------------------------------------
// Operation codes and fixed values
// ----------------------------------------------------------------------
`define TPE_OP_WRITE    1'b0
`define TPE_OP_POP      1'b1
`define TPE_WORD_ZERO   16'h0000
`define TPE_WORD_ONE    16'h0001
`define TPE_FLAG_RST    1'b0

`endif

// ---- src/tpe_pkg.sv ----
/*
  Types of the table push/pop engine.
  Assumes tpe_map.svh supplies the numeric constants.
*/
package tpe_pkg;

  // --------------------------------------------------------------------
  // Engine sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    tpe_st_idle,
    tpe_st_qwait,
    tpe_st_shift
  } tpe_state_t;

endpackage : tpe_pkg

// ---- src/tpe_stt_step.sv ----
/*
  Pointer step of the circular write: which slot a pointer selects, the
  pointer that follows, and whether the store may happen at all.
  Assumes pointer and length are sampled on the same clock by the caller.
*/
`timescale 1ns/1ps
`include "tpe_map.svh"

module tpe_stt_step (
  input  wire logic [`TPE_WORD_W-1:0] ptr_in,
  input  wire logic [`TPE_LEN_W-1:0]  len_in,
  output logic      [`TPE_WORD_W-1:0] slot_off_out,
  output logic      [`TPE_WORD_W-1:0] next_ptr_out,
  output logic                        store_ok_out,
  output logic                        at_end_out
);

  logic [`TPE_WORD_W-1:0] len_word;
  logic [`TPE_WORD_W-1:0] ptr_inc;

  // ----------------------------------------------------------------------
  // Step arithmetic
  // ----------------------------------------------------------------------
  // Zero only occurs before the first store, so like the length it selects the first slot
  assign len_word     = {{(`TPE_WORD_W-`TPE_LEN_W){1'b0}}, len_in};
  assign ptr_inc      = ptr_in + `TPE_WORD_ONE;
  assign at_end_out   = (ptr_in == len_word);
  assign store_ok_out = (len_in != '0) && (ptr_in <= len_word);
  assign slot_off_out = (ptr_in == `TPE_WORD_ZERO || at_end_out)
                        ? `TPE_WORD_ONE : ptr_inc;
  assign next_ptr_out = at_end_out ? `TPE_WORD_ONE : ptr_inc;

endmodule : tpe_stt_step

// ---- src/tpe_fifo.sv ----
/*
  Small shift-register queue for popped words.  Head word and flags are
  flip-flops so the consumer sees registered outputs.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "tpe_map.svh"

module tpe_fifo #(
  parameter int unsigned WIDTH = `TPE_WORD_W,
  parameter int unsigned DEPTH = `TPE_FIFO_DEPTH
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] slot_reg [0:DEPTH-1];
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic [CW-1:0]    wr_pos;
  logic             full_reg;
  logic             valid_reg;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------------
  // Handshake terms
  // ----------------------------------------------------------------------
  assign push          = in_valid_in && !full_reg;
  assign pop           = valid_reg && out_ready_in;
  assign wr_pos        = pop ? count_reg - CW'(1) : count_reg;
  assign count_next    = count_reg + CW'(push) - CW'(pop);
  assign in_ready_out  = !full_reg;
  assign out_valid_out = valid_reg;
  assign out_data_out  = slot_reg[0];

  // Storage shifts toward the head; a pop and a push may share a cycle
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < DEPTH; i++)
        slot_reg[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (push && wr_pos == CW'(i))
          slot_reg[i] <= in_data_in;
        else if (pop)
          slot_reg[i] <= (i < DEPTH - 1) ? slot_reg[(i + 1) % DEPTH] : '0;
      end
    end
  end

  // Occupancy and registered flags
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      count_reg <= '0;
      full_reg  <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      full_reg  <= (count_next == CW'(DEPTH));
      valid_reg <= (count_next != '0);
    end
  end

endmodule : tpe_fifo

// ---- tb/tpe_chk_sva.sv ----
/*
  Port checker for tpe_engine: done, busy, flag, read and queue timing.
  Assumes it is bound to tpe_engine and sees one clock domain.
*/
`timescale 1ns/1ps
`include "tpe_map.svh"

module tpe_chk (
  input wire logic                   clk_in,
  input wire logic                   rstn_in,
  input wire logic                   exec_in,
  input wire logic                   op_sel_in,
  input wire logic                   enable_in,
  input wire logic                   scan_end_in,
  input wire logic                   mem_rd_in,
  input wire logic                   mem_rvalid_out,
  input wire logic                   busy_out,
  input wire logic                   done_out,
  input wire logic                   table_status_flag_out,
  input wire logic                   pop_valid_out,
  input wire logic [`TPE_WORD_W-1:0] pop_data_out,
  input wire logic                   pop_ready_in
);
  // ------------------------------------------------------------------
  // Properties, all on the one clock
  // ------------------------------------------------------------------
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // Sequence end always reports completion
  property p_busy_done;
    $fell(busy_out) |-> done_out;
  endproperty
  a_busy_done: assert property (p_busy_done)
    else $error("busy ended without done");

  // Only an enabled pop request starts a sequence
  property p_busy_rise;
    $rose(busy_out) |-> $past(exec_in && op_sel_in && enable_in);
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy rose without pop request");

  // Completion has a cause one cycle earlier
  property p_done_cause;
    done_out |-> $past(exec_in && enable_in) || $past(busy_out);
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done without request");

  // Done never overlaps a running sequence
  property p_done_idle;
    done_out |-> !busy_out;
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("done while busy");

  // Scan end clears the flag when nothing updates it
  property p_flag_clear;
    scan_end_in && !exec_in && !busy_out |=> !table_status_flag_out;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag survived scan end");

  // Flag only moves on an operation or a scan end
  property p_flag_hold;
    !scan_end_in && !exec_in && !busy_out
      |=> $stable(table_status_flag_out);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag changed with no cause");

  // Host read answers in the next cycle
  property p_mrd;
    mem_rd_in |=> mem_rvalid_out;
  endproperty
  a_mrd: assert property (p_mrd)
    else $error("read gave no valid");

  // A stalled queue head stays put
  property p_fifo_hold;
    pop_valid_out && !pop_ready_in |=> pop_valid_out && $stable(pop_data_out);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold)
    else $error("queue head lost while stalled");

endmodule : tpe_chk

bind tpe_engine tpe_chk u_chk (
  .clk_in(clk_in), .rstn_in(rstn_in), .exec_in(exec_in),
  .op_sel_in(op_sel_in), .enable_in(enable_in), .scan_end_in(scan_end_in),
  .mem_rd_in(mem_rd_in), .mem_rvalid_out(mem_rvalid_out),
  .busy_out(busy_out), .done_out(done_out),
  .table_status_flag_out(table_status_flag_out),
  .pop_valid_out(pop_valid_out), .pop_data_out(pop_data_out),
  .pop_ready_in(pop_ready_in)
);

// ---- tb/testbench.sv ----
/*
  Bench for tpe_engine: circular write, refusals, pop with shift, queue
  fill and drain, skipped pops.  Assumes the checker is bound in.
*/
`timescale 1ns/1ps
`include "tpe_map.svh"

module testbench;
  // ------------------------------------------------------------------
  // Signals and bench state
  // ------------------------------------------------------------------
  logic        clk_in = 1'b0, rstn_in = 1'b0, exec_in = 1'b0;
  logic        op_sel_in = 1'b0, enable_in = 1'b0, scan_end_in = 1'b0;
  logic        mem_wr_in = 1'b0, mem_rd_in = 1'b0, pop_ready_in = 1'b0;
  logic [15:0] base_addr_in = 16'h0000, operand_addr_in = 16'h0000;
  logic [15:0] mem_addr_in = 16'h0000, mem_wdata_in = 16'h0000;
  logic [7:0]  table_len_in = 8'h00;
  logic [15:0] mem_rdata_out, pop_data_out, r, v, q[1:6], expq[$];
  logic        mem_rvalid_out, busy_out, done_out, flag, pop_valid_out, d;
  int          mismatches = 0, compares = 0, seed = 32'h42dc, p, L, N, k;

  // 10 MHz clock
  always #50 clk_in = ~clk_in;

  tpe_engine u_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .exec_in(exec_in),
    .op_sel_in(op_sel_in), .enable_in(enable_in),
    .scan_end_in(scan_end_in), .base_addr_in(base_addr_in),
    .table_len_in(table_len_in), .operand_addr_in(operand_addr_in),
    .mem_wr_in(mem_wr_in), .mem_rd_in(mem_rd_in),
    .mem_addr_in(mem_addr_in), .mem_wdata_in(mem_wdata_in),
    .mem_rdata_out(mem_rdata_out), .mem_rvalid_out(mem_rvalid_out),
    .busy_out(busy_out), .done_out(done_out),
    .table_status_flag_out(flag), .pop_valid_out(pop_valid_out),
    .pop_data_out(pop_data_out), .pop_ready_in(pop_ready_in)
  );

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  // Write pointer and slot index agree: zero and the length both give 1
  function automatic logic [15:0] nxt(input int pp, input int ll);
    return (pp == ll) ? 16'h0001 : 16'(pp + 1);
  endfunction : nxt

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic mwr(input logic [15:0] a, input logic [15:0] dat);
    @(negedge clk_in);
    mem_wr_in = 1'b1;
    mem_addr_in = a;
    mem_wdata_in = dat;
    @(negedge clk_in);
    mem_wr_in = 1'b0;
  endtask : mwr

  // Read data is taken in the cycle its valid pulse stands
  task automatic mrd(input logic [15:0] a);
    @(negedge clk_in);
    mem_rd_in = 1'b1;
    mem_addr_in = a;
    @(negedge clk_in);
    mem_rd_in = 1'b0;
    chk(16'(mem_rvalid_out), 16'h0001);
    r = mem_rdata_out;
  endtask : mrd

  // Scan end leads the request by a cycle, so the request opens a new scan
  task automatic issue(input logic sel, input logic en, input logic se);
    @(negedge clk_in);
    scan_end_in = se;
    @(negedge clk_in);
    scan_end_in = 1'b0;
    exec_in = 1'b1;
    op_sel_in = sel;
    enable_in = en;
    @(negedge clk_in);
    exec_in = 1'b0;
  endtask : issue

  // Bounded wait; done is a one-cycle pulse so every cycle is looked at
  task automatic wdone(input int n);
    d = done_out;
    while (d !== 1'b1 && n > 0)
    begin
      @(negedge clk_in);
      d = done_out;
      n--;
    end
  endtask : wdone

  task automatic end_sim;
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected run length
  initial
  begin
    #(20000 * 100);
    mismatches++;
    end_sim();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (5) @(negedge clk_in);
    rstn_in = 1'b1;
    // Circular write over more than two laps of a random length
    L = 3 + ($random(seed) & 3);
    base_addr_in = 16'h0040;
    table_len_in = 8'(L);
    operand_addr_in = 16'h0100;
    p = 0;
    mwr(16'h0040, 16'h0000);
    for (k = 0; k < 2 * L + 1; k++)
    begin
      v = 16'($random(seed));
      mwr(16'h0100, v);
      issue(1'b0, 1'b1, 1'b1);
      wdone(5);
      chk(16'(d), 16'h0001);
      chk(16'(flag), 16'(p == L));
      mrd(16'h0040 + nxt(p, L));
      chk(r, v);
      p = nxt(p, L);
      mrd(16'h0040);
      chk(r, 16'(p));
    end
    // Enable off, one take, then a second request in the same scan
    issue(1'b0, 1'b0, 1'b1);
    wdone(20);
    chk(16'(d), 16'h0000);
    issue(1'b0, 1'b1, 1'b0);
    wdone(5);
    chk(16'(d), 16'h0001);
    p = nxt(p, L);
    issue(1'b0, 1'b1, 1'b0);
    wdone(20);
    chk(16'(d), 16'h0000);
    mrd(16'h0040);
    chk(r, 16'(p));
    // Pointer past the length: nothing stored, pointer kept
    mwr(16'h0040, 16'(L + 1));
    issue(1'b0, 1'b1, 1'b1);
    wdone(5);
    chk(16'(flag), 16'h0000);
    mrd(16'h0040 + 16'(L + 2));
    chk(r, 16'h0000);
    mrd(16'h0040);
    chk(r, 16'(L + 1));
    $display("Write tests done");
    // Pop with counter 5 of 6; queue stalled until the fifth waits
    base_addr_in = 16'h0080;
    table_len_in = 8'h06;
    operand_addr_in = 16'h0180;
    for (k = 1; k <= 6; k++)
    begin
      q[k] = 16'($random(seed));
      mwr(16'h0080 + 16'(k), q[k]);
    end
    N = 5;
    mwr(16'h0080, 16'h0005);
    for (k = 1; k <= 5; k++)
    begin
      issue(1'b1, 1'b1, 1'b1);
      wdone(k < 5 ? 30 : 10);
      chk(16'(d), 16'(k < 5));
      v = q[1];
      expq.push_back(v);
      for (p = 1; p < N; p++)
        q[p] = q[p + 1];
      q[N] = 16'h0000;
      N--;
      if (k < 5)
      begin
        chk(16'(flag), 16'h0000);
        mrd(16'h0080);
        chk(r, 16'(N));
      end
    end
    chk(16'(busy_out), 16'h0001);
    // Drain: each head is checked before the edge that takes it
    pop_ready_in = 1'b1;
    d = 1'b0;
    repeat (40)
    begin
      if (pop_valid_out === 1'b1 && expq.size() > 0)
        chk(pop_data_out, expq.pop_front());
      if (done_out === 1'b1)
        d = 1'b1;
      @(negedge clk_in);
    end
    chk(16'(d), 16'h0001);
    chk(16'(expq.size()), 16'h0000);
    chk(16'(pop_valid_out), 16'h0000);
    chk(16'(flag), 16'h0001);
    for (k = 0; k <= 6; k++)
    begin
      mrd(16'h0080 + 16'(k));
      chk(r, k == 0 ? 16'h0000 : q[k]);
    end
    // Counter at zero, then above the length: skipped, flag raised
    for (k = 0; k < 2; k++)
    begin
      @(negedge clk_in);
      scan_end_in = 1'b1;
      @(negedge clk_in);
      scan_end_in = 1'b0;
      chk(16'(flag), 16'h0000);
      mwr(16'h0080, k == 0 ? 16'h0000 : 16'h0007);
      issue(1'b1, 1'b1, 1'b1);
      wdone(5);
      chk(16'(flag), 16'h0001);
      mrd(16'h0080);
      chk(r, k == 0 ? 16'h0000 : 16'h0007);
      mrd(16'h0180);
      chk(r, v);
    end
    $display("Pop tests done");
    end_sim();
  end

endmodule : testbench
